// file: seb_pkg.sv
// seb_pkg: register map, field positions, reset values and sizes of the spi block
// assumes a 32-bit avalon-mm slave with byte addresses and 16-bit registers
`default_nettype none
package seb_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned PTR_W = 3;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned DIV_W = 8;
    localparam int unsigned EDGE_CNT_W = 5;
    localparam logic [4:0] LAST_EDGE = 5'h1f;
    localparam logic [4:0] LAST_SAMPLE = 5'h0f;

    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL2 = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_BUFFER = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_ALT_MAP = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 5'h18;

    // status register fields
    localparam int unsigned ST_RX_AVAIL = 0;
    localparam int unsigned ST_TX_FULL = 1;
    localparam int unsigned ST_TX_EMPTY = 2;
    localparam int unsigned ST_BUSY = 4;
    localparam int unsigned ST_RX_OVERFLOW = 6;
    localparam int unsigned ST_WRITE_COLLISION = 7;
    localparam int unsigned ST_PORT_ON = 15;
    // control register 1 fields
    localparam int unsigned C1_PRESCALE_LSB = 0;
    localparam int unsigned C1_MASTER = 5;
    localparam int unsigned C1_CLK_IDLE_HIGH = 6;
    localparam int unsigned C1_SS_PIN_EN = 7;
    localparam int unsigned C1_CLK_EDGE = 8;
    localparam int unsigned C1_SAMPLE_PHASE = 9;
    localparam logic [15:0] C1_MASK = 16'h03e7;
    // control register 2 and alternate map fields
    localparam int unsigned C2_ENH_BUFFER = 0;
    localparam int unsigned ALT_CLK_SEL = 0;
    localparam logic [15:0] ALT_MASK = 16'h0001;
    // interrupt status and mask fields
    localparam int unsigned IRQ_RX_WORD = 0;
    localparam int unsigned IRQ_TX_EMPTY = 1;
    localparam int unsigned IRQ_OVERFLOW = 2;
    localparam int unsigned IRQ_W = 3;

    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage
`default_nettype wire

// file: seb_link_if.sv
// seb_link_if: configuration and word handshake between register side and shift engine
// assumes both ends run on the same system clock
`default_nettype none
interface seb_link_if;
    logic en;
    logic master;
    logic clk_idle_high;
    logic clk_edge;
    logic sample_phase;
    logic ss_pin_en;
    logic [2:0] prescale;
    logic tx_valid;
    logic [15:0] tx_word;
    logic tx_take;
    logic rx_done;
    logic [15:0] rx_word;
    logic busy;
    modport core (output en, master, clk_idle_high, clk_edge, sample_phase, ss_pin_en,
                  prescale, tx_valid, tx_word, input tx_take, rx_done, rx_word, busy);
    modport eng (input en, master, clk_idle_high, clk_edge, sample_phase, ss_pin_en,
                 prescale, tx_valid, tx_word, output tx_take, rx_done, rx_word, busy);
endinterface
`default_nettype wire

// file: seb_shift.sv
// seb_shift: serial shift engine, master clock generator and slave edge finder
// assumes pin inputs are asynchronous to mclk_i and are synchronised here
`default_nettype none
module seb_shift (
    input wire logic mclk_i,
    input wire logic rst_i,
    seb_link_if.eng lk,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic ss_n_i,
    output logic sclk_o,
    output logic sdo_o
);
    typedef enum logic {SEB_IDLE, SEB_RUN} seb_state_e;
    seb_state_e state;
    logic [2:0] sclk_sy;
    logic [1:0] ss_sy;
    logic [2:0] sdi_sy;
    logic [seb_pkg::DIV_W-1:0] div;
    logic [seb_pkg::EDGE_CNT_W-1:0] edges;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic fresh;
    logic tick, lead_e, trail_e, sample_e, shift_e, sdi_v, active, s_rise, s_fall;
    localparam int unsigned DIV_W = seb_pkg::DIV_W;
    localparam int unsigned EDGE_CNT_W = seb_pkg::EDGE_CNT_W;

    always_ff @(posedge mclk_i)
    begin
        sclk_sy <= {sclk_sy[1:0], sclk_i};
        ss_sy <= {ss_sy[0], ss_n_i};
        sdi_sy <= {sdi_sy[1:0], sdi_i};
    end

    // a late sample trades one system clock of setup for more hold at the far end
    assign sdi_v = (lk.master && lk.sample_phase) ? sdi_sy[2] : sdi_sy[1];
    assign s_rise = sclk_sy[1] && !sclk_sy[2];
    assign s_fall = !sclk_sy[1] && sclk_sy[2];
    assign active = !lk.ss_pin_en || !ss_sy[1];
    assign tick = (div == DIV_W'((8'h01 << lk.prescale) - 8'h01));

    always_comb
    begin
        if (lk.master)
        begin
            lead_e = (state == SEB_RUN) && tick && !edges[0];
            trail_e = (state == SEB_RUN) && tick && edges[0];
        end
        else
        begin
            // slave follows only the external clock edges
            lead_e = (state == SEB_RUN) && active && (lk.clk_idle_high ? s_fall : s_rise);
            trail_e = (state == SEB_RUN) && active && (lk.clk_idle_high ? s_rise : s_fall);
        end
    end
    assign sample_e = lk.clk_edge ? trail_e : lead_e;
    assign shift_e = lk.clk_edge ? lead_e : trail_e;

    // a word is taken as soon as it is offered to an idle enabled engine, master or slave
    assign lk.tx_take = (state == SEB_IDLE) && lk.en && lk.tx_valid;
    assign lk.busy = (state == SEB_RUN);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !lk.en)
            state <= SEB_IDLE;
        // a deselected slave stays idle until a word is queued, so a word queued before select goes out first
        else if (state == SEB_IDLE && (lk.tx_valid || (!lk.master && active)))
            state <= SEB_RUN;
        else if (lk.master && tick && edges == seb_pkg::LAST_EDGE)
            state <= SEB_IDLE;
        else if (!lk.master && sample_e && edges == seb_pkg::LAST_SAMPLE)
            state <= SEB_IDLE;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || state == SEB_IDLE || tick)
            div <= '0;
        else
            div <= div + DIV_W'(1);
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || state == SEB_IDLE || (!lk.master && !active))
            edges <= '0;
        else if (lk.master ? tick : sample_e)
            edges <= edges + EDGE_CNT_W'(1);
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !lk.en || !lk.master)
            sclk_o <= 1'b0;
        else if (state == SEB_IDLE)
            sclk_o <= lk.clk_idle_high;
        else if (tick)
            sclk_o <= !sclk_o;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_sh <= '0;
            fresh <= 1'b0;
        end
        else if (state == SEB_IDLE)
        begin
            // an idle slave with nothing queued answers with zeros
            tx_sh <= lk.tx_valid ? lk.tx_word : '0;
            fresh <= lk.clk_edge;
        end
        else if (shift_e)
        begin
            fresh <= 1'b0;
            if (!fresh)
                tx_sh <= {tx_sh[14:0], 1'b0};
        end
    end
    assign sdo_o = tx_sh[15];

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rx_sh <= '0;
        else if (sample_e)
            rx_sh <= {rx_sh[14:0], sdi_v};
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            lk.rx_done <= 1'b0;
            lk.rx_word <= '0;
        end
        else
        begin
            lk.rx_done <= 1'b0;
            if (state == SEB_RUN && (lk.master ? (tick && edges == seb_pkg::LAST_EDGE)
                : (sample_e && edges == seb_pkg::LAST_SAMPLE)))
            begin
                lk.rx_done <= 1'b1;
                lk.rx_word <= lk.master ? rx_sh : {rx_sh[14:0], sdi_v};
            end
        end
    end
endmodule
`default_nettype wire

// file: seb_core.sv
// seb_core: spi port with enhanced buffers, avalon-mm register slave and interrupt logic
// assumes an avalon-mm master on mclk_i and an spi peer on asynchronous pins
`default_nettype none
// Overview of operation
// - Receive overflow sits in status bit 6 and software can clear it before buffer mode.
// - Control register 2 bit 0 selects enhanced buffer mode, chosen before enabling.
// - Status bit 15 switches serial operation on, as the last setup step.
// - An enabled master starts shifting out and in as soon as a word is written.
// - With the alternate clock select at one the clock leaves only on the fixed pin.
// - With the alternate clock select at zero the clock goes to the per-pin mapping.
// - Alternate map bits 15 to 1 read zero and bit 0 resets to zero.
module seb_core (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sclk_i,
    output logic first_port_clock_output_o,
    output logic first_port_clock_output_oe_n_o,
    output logic alternate_fixed_clock_pin_o,
    output logic alternate_fixed_clock_pin_oe_n_o,
    input wire logic sdi_i,
    output logic sdo_o,
    input wire logic ss_n_i,
    output logic irq_o
);
    seb_link_if lk ();

    logic ack;
    logic acc_wr, acc_rd;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [15:0] control_register_1;
    logic [15:0] control_register_2;
    logic [15:0] alternate_clock_pin_map;
    logic serial_port_on;
    logic receive_overflow_flag;
    logic write_collision;
    logic [seb_pkg::IRQ_W-1:0] int_status;
    logic [seb_pkg::IRQ_W-1:0] int_mask;
    logic [seb_pkg::IRQ_W-1:0] int_event;
    logic [15:0] tx_mem [seb_pkg::FIFO_DEPTH];
    logic [15:0] rx_mem [seb_pkg::FIFO_DEPTH];
    logic [seb_pkg::PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [seb_pkg::CNT_W-1:0] tx_cnt, rx_cnt, cap;
    logic tx_full, rx_full, tx_push, rx_pop, rx_push, tx_empty_q;
    logic sclk_int;
    logic alt_sel;
    logic [15:0] status_view;
    logic [31:0] next_readdata;

    // merges the enabled byte lanes of a write into a register
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] m,
                                             input logic [15:0] d);
        merge16 = (old_v & ~m) | (d & m);
    endfunction

    // a ring pointer step that wraps to fit the current capacity
    function automatic logic [2:0] bump(input logic [2:0] p, input logic [3:0] c);
        bump = (4'(p) + 4'h1 >= c) ? 3'h0 : p + 3'h1;
    endfunction

    // ---------------- avalon-mm slave ----------------
    // one wait cycle per access; ack lasts one cycle so a held request is served once
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= (avs_read_i || avs_write_i) && !ack;
    end
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign acc_wr = avs_write_i && ack;
    assign acc_rd = avs_read_i && ack;
    assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wdata = avs_writedata_i[15:0];

    // ---------------- configuration registers ----------------
    // master select, edge, polarity, pin enable and sample phase come from software,
    // which orders its setup writes before enabling
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            control_register_1 <= seb_pkg::RST_REG;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_CTRL1)
            control_register_1 <= merge16(control_register_1, wmask & seb_pkg::C1_MASK, wdata);
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            control_register_2 <= seb_pkg::RST_REG;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_CTRL2 && !serial_port_on)
            // buffer mode is frozen while the port runs, since it resizes the queues
            control_register_2[seb_pkg::C2_ENH_BUFFER] <= avs_byteenable_i[0] ?
                wdata[seb_pkg::C2_ENH_BUFFER] : control_register_2[seb_pkg::C2_ENH_BUFFER];
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            alternate_clock_pin_map <= seb_pkg::RST_REG;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_ALT_MAP)
            alternate_clock_pin_map <= merge16(alternate_clock_pin_map,
                                               wmask & seb_pkg::ALT_MASK, wdata);
    end
    // software keeps this stable while the port is on
    assign alt_sel = alternate_clock_pin_map[seb_pkg::ALT_CLK_SEL];

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            serial_port_on <= 1'b0;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_STATUS && avs_byteenable_i[1])
            serial_port_on <= wdata[seb_pkg::ST_PORT_ON];
    end

    // overflow and collision clear by writing zero; a new event in that cycle wins
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            receive_overflow_flag <= 1'b0;
        else if (rx_push && rx_full)
            receive_overflow_flag <= 1'b1;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_STATUS && avs_byteenable_i[0]
                 && !wdata[seb_pkg::ST_RX_OVERFLOW])
            receive_overflow_flag <= 1'b0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            write_collision <= 1'b0;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_BUFFER && tx_full && serial_port_on)
            write_collision <= 1'b1;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_STATUS && avs_byteenable_i[0]
                 && !wdata[seb_pkg::ST_WRITE_COLLISION])
            write_collision <= 1'b0;
    end

    // ---------------- transmit and receive queues ----------------
    localparam int unsigned CNT_W = seb_pkg::CNT_W;
    // eight words deep in enhanced buffer mode, one word otherwise
    assign cap = control_register_2[seb_pkg::C2_ENH_BUFFER] ?
                 CNT_W'(seb_pkg::FIFO_DEPTH) : CNT_W'(1);
    assign tx_full = (tx_cnt >= cap);
    assign rx_full = (rx_cnt >= cap);
    assign tx_push = acc_wr && avs_address_i == seb_pkg::OFS_BUFFER && !tx_full
                     && serial_port_on && |avs_byteenable_i[1:0];
    assign rx_pop = acc_rd && avs_address_i == seb_pkg::OFS_BUFFER && rx_cnt != '0;
    assign rx_push = lk.rx_done;

    // a disabled port drops all queued words, which is how the buffer is cleared
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !serial_port_on)
        begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp <= bump(tx_wp, cap);
            if (lk.tx_take)
                tx_rp <= bump(tx_rp, cap);
            tx_cnt <= tx_cnt + CNT_W'(tx_push) - CNT_W'(lk.tx_take);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (tx_push)
            tx_mem[tx_wp] <= wdata;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !serial_port_on)
        begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
        end
        else
        begin
            // a word arriving into a full queue is lost and flags overflow
            if (rx_push && !rx_full)
                rx_wp <= bump(rx_wp, cap);
            if (rx_pop)
                rx_rp <= bump(rx_rp, cap);
            rx_cnt <= rx_cnt + CNT_W'(rx_push && !rx_full) - CNT_W'(rx_pop);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rx_push && !rx_full)
            rx_mem[rx_wp] <= lk.rx_word;
    end

    // ---------------- shift engine ----------------
    assign lk.en = serial_port_on;
    assign lk.master = control_register_1[seb_pkg::C1_MASTER];
    assign lk.clk_idle_high = control_register_1[seb_pkg::C1_CLK_IDLE_HIGH];
    assign lk.clk_edge = control_register_1[seb_pkg::C1_CLK_EDGE];
    assign lk.sample_phase = control_register_1[seb_pkg::C1_SAMPLE_PHASE];
    assign lk.ss_pin_en = control_register_1[seb_pkg::C1_SS_PIN_EN];
    assign lk.prescale = control_register_1[seb_pkg::C1_PRESCALE_LSB +: 3];
    assign lk.tx_valid = (tx_cnt != '0);
    assign lk.tx_word = tx_mem[tx_rp];

    seb_shift u_shift (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .lk(lk),
        .sclk_i(sclk_i),
        .sdi_i(sdi_i),
        .ss_n_i(ss_n_i),
        .sclk_o(sclk_int),
        .sdo_o(sdo_o)
    );

    // ---------------- clock pin routing ----------------
    // a slave never drives either clock pin
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            alternate_fixed_clock_pin_o <= 1'b0;
            alternate_fixed_clock_pin_oe_n_o <= 1'b1;
            first_port_clock_output_o <= 1'b0;
            first_port_clock_output_oe_n_o <= 1'b1;
        end
        else
        begin
            alternate_fixed_clock_pin_o <= alt_sel ? sclk_int : 1'b0;
            alternate_fixed_clock_pin_oe_n_o <= !(alt_sel && lk.en && lk.master);
            first_port_clock_output_o <= alt_sel ? 1'b0 : sclk_int;
            first_port_clock_output_oe_n_o <= !(!alt_sel && lk.en && lk.master);
        end
    end

    // ---------------- interrupts ----------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            tx_empty_q <= 1'b1;
        else
            tx_empty_q <= (tx_cnt == '0);
    end
    assign int_event[seb_pkg::IRQ_RX_WORD] = rx_push && !rx_full;
    assign int_event[seb_pkg::IRQ_TX_EMPTY] = (tx_cnt == '0) && !tx_empty_q;
    assign int_event[seb_pkg::IRQ_OVERFLOW] = rx_push && rx_full;

    // write one to clear; an event in the same cycle keeps its bit set
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            int_status <= '0;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_INT_STATUS && avs_byteenable_i[0])
            int_status <= (int_status & ~wdata[seb_pkg::IRQ_W-1:0]) | int_event;
        else
            int_status <= int_status | int_event;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            int_mask <= '0;
        else if (acc_wr && avs_address_i == seb_pkg::OFS_INT_MASK && avs_byteenable_i[0])
            int_mask <= wdata[seb_pkg::IRQ_W-1:0];
    end
    assign irq_o = |(int_status & int_mask);

    // ---------------- read path ----------------
    always_comb
    begin
        status_view = '0;
        status_view[seb_pkg::ST_RX_AVAIL] = (rx_cnt != '0);
        status_view[seb_pkg::ST_TX_FULL] = tx_full;
        status_view[seb_pkg::ST_TX_EMPTY] = (tx_cnt == '0);
        status_view[seb_pkg::ST_BUSY] = lk.busy;
        status_view[seb_pkg::ST_RX_OVERFLOW] = receive_overflow_flag;
        status_view[seb_pkg::ST_WRITE_COLLISION] = write_collision;
        status_view[seb_pkg::ST_PORT_ON] = serial_port_on;
    end

    always_comb
    begin
        next_readdata = seb_pkg::RD_UNMAPPED;
        unique case (avs_address_i)
            seb_pkg::OFS_STATUS: next_readdata = {16'h0000, status_view};
            seb_pkg::OFS_CTRL1: next_readdata = {16'h0000, control_register_1};
            seb_pkg::OFS_CTRL2: next_readdata = {16'h0000, control_register_2};
            seb_pkg::OFS_BUFFER: next_readdata = {16'h0000, (rx_cnt != '0) ?
                                                  rx_mem[rx_rp] : 16'h0000};
            seb_pkg::OFS_ALT_MAP: next_readdata = {16'h0000, alternate_clock_pin_map};
            seb_pkg::OFS_INT_STATUS: next_readdata = {29'h0000_0000, int_status};
            seb_pkg::OFS_INT_MASK: next_readdata = {29'h0000_0000, int_mask};
            default: next_readdata = seb_pkg::RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            avs_readdata_o <= '0;
        else if (avs_read_i && !ack)
            avs_readdata_o <= next_readdata;
    end
endmodule
`default_nettype wire

// file: seb_core_properties.sv
// seb_core_properties: bus, pin and interrupt checks on the seb_core ports
// assumes a bus master that holds each request until waitrequest is low
`default_nettype none
module seb_core_properties (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic first_port_clock_output_oe_n_o,
    input wire logic alternate_fixed_clock_pin_oe_n_o,
    input wire logic irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire logic f_off = first_port_clock_output_oe_n_o;
    wire logic a_off = alternate_fixed_clock_pin_oe_n_o;
    wire logic done_rd = avs_read_i && !avs_waitrequest_o;
    sequence s_req;
        $rose(avs_read_i || avs_write_i);
    endsequence
    sequence s_ans;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    a_one_wait: assert property (s_req |-> s_ans) else $error("wait cycle count wrong");
    a_idle_no_wait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest without request");
    a_read_upper_zero: assert property (done_rd |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_alt_map_zero: assert property (done_rd && avs_address_i == seb_pkg::OFS_ALT_MAP
        |-> avs_readdata_o[31:1] == 31'h0) else $error("alternate map spare bits set");
    a_unmapped_zero: assert property (done_rd && avs_address_i == 5'h1c
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    a_one_clock_pin: assert property (f_off || a_off) else $error("both clock pins driven");
    a_quiet_after_reset: assert property ($fell(rst_i) |-> f_off && a_off && !irq_o)
        else $error("outputs active after reset");
    a_pin_mode_by_write: assert property ($changed({f_off, a_off})
        |-> $past(avs_write_i, 1) || $past(avs_write_i, 2) || $past(avs_write_i, 3))
        else $error("clock pin changed without write");
endmodule
`default_nettype wire

// file: seb_peer.sv
// seb_peer: spi partner, slave to the device clock or master at a 125 ns link clock
// assumes dev_on_i is high while the device drives one of its clock pins
`default_nettype none
module seb_peer (
    input wire logic dev_clk_i,
    input wire logic dev_on_i,
    input wire logic go_i,
    input wire logic [15:0] word_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic sdi_o,
    output logic [15:0] rx_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] sh = 16'h0000;
    logic gen = 1'b0;
    wire logic ck = dev_on_i ? dev_clk_i : gen;
    assign sclk_o = gen;
    assign sdi_o = sh[15];
    initial rx_o = 16'h0000;
    // own clock runs only inside a frame and idles low
    always @(posedge go_i)
    begin
        sh = word_i;
        if (!dev_on_i)
            repeat (16)
            begin
                #62.5 gen = 1'b1;
                #62.5 gen = 1'b0;
            end
    end
    always @(posedge ck) rx_o <= {rx_o[14:0], sdo_i};
    // inverted fill so a stale bit never passes for data
    always @(negedge ck) sh <= {sh[14:0], ~sh[0]};
endmodule
`default_nettype wire

// file: test_spi_enhanced_buffer_setup.sv
// test_spi_enhanced_buffer_setup: setup, transfers and registers of seb_core
// assumes seb_peer on the serial pins and one 125 MHz system clock
`default_nettype none
module test_spi_enhanced_buffer_setup;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 0, rst_i = 1, rd = 0, wr = 0, ss_n = 1, go = 0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] pword = 16'h0, q, prx;
    logic wait_o, sclk, sdi, fck, fck_oe_n, aclk, aclk_oe_n, sdo, irq;
    int fail_count = 0, compares = 0;
    wire logic dclk = (fck & ~fck_oe_n) | (aclk & ~aclk_oe_n);
    seb_core dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h3),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .sclk_i(sclk),
        .first_port_clock_output_o(fck), .first_port_clock_output_oe_n_o(fck_oe_n),
        .alternate_fixed_clock_pin_o(aclk), .alternate_fixed_clock_pin_oe_n_o(aclk_oe_n),
        .sdi_i(sdi), .sdo_o(sdo), .ss_n_i(ss_n), .irq_o(irq)
    );
    seb_peer peer_u (.dev_clk_i(dclk), .dev_on_i(~fck_oe_n | ~aclk_oe_n), .go_i(go),
        .word_i(pword), .sdo_i(sdo), .sclk_o(sclk), .sdi_o(sdi), .rx_o(prx));
    initial forever #4 mclk_i = ~mclk_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge; data taken at that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        int n = 0;
        @(posedge mclk_i);
        addr <= a;
        wdat <= {16'h0000, d};
        rd <= !w;
        wr <= w;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (wait_o !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        q = rdat[15:0];
        rd <= 0;
        wr <= 0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        bus(0, a, 16'h0);
        chk(q, exp);
    endtask
    task automatic poll(input logic [4:0] a, input int b);
        for (int n = 0; n < 400; n++)
        begin
            bus(0, a, 16'h0);
            if (q[b] === 1'b1) break;
        end
        chk(q[b], 1'b1);
    endtask
    task automatic t_regs();
        rchk(5'h10, 16'h0000);
        bus(1, 5'h10, 16'hffff);
        rchk(5'h10, 16'h0001);
        bus(1, 5'h1c, 16'hffff);
        rchk(5'h1c, 16'h0000);
        bus(1, 5'h10, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_master(input logic alt, input logic [15:0] tx, input logic [15:0] rx);
        bus(1, 5'h18, 16'h0001);
        bus(1, 5'h14, 16'h0007);
        bus(1, 5'h04, 16'h0023);
        bus(1, 5'h00, 16'h0000);
        bus(1, 5'h08, 16'h0001);
        bus(1, 5'h10, {15'h0, alt});
        bus(1, 5'h00, 16'h8000);
        rchk(5'h00, 16'h8004);
        chk({fck_oe_n, aclk_oe_n}, alt ? 2'b10 : 2'b01);
        pword <= rx;
        go <= 1;
        bus(1, 5'h0c, tx);
        go <= 0;
        for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge mclk_i);
        chk(irq, 1'b1);
        rchk(5'h0c, rx);
        chk(prx, tx);
        bus(1, 5'h14, 16'h0007);
        #1;
        chk(irq, 1'b0);
        bus(1, 5'h00, 16'h0000);
        bus(1, 5'h10, 16'h0000);
        $display("test master done");
    endtask
    task automatic t_ovf();
        bus(1, 5'h04, 16'h0023);
        bus(1, 5'h08, 16'h0000);
        bus(1, 5'h00, 16'h8000);
        for (int n = 0; n < 2; n++)
        begin
            bus(1, 5'h0c, 16'h00ff);
            poll(5'h14, 2 * n);
            bus(1, 5'h14, 16'h0007);
        end
        bus(0, 5'h00, 16'h0);
        chk(q[6], 1'b1);
        bus(1, 5'h00, 16'h8000);
        bus(0, 5'h00, 16'h0);
        chk(q[6], 1'b0);
        bus(1, 5'h00, 16'h0000);
        $display("test overflow done");
    endtask
    task automatic t_slave();
        rchk(5'h0c, 16'h0000);
        bus(1, 5'h04, 16'h0080);
        bus(1, 5'h08, 16'h0001);
        bus(1, 5'h00, 16'h8000);
        bus(1, 5'h0c, 16'h5aa5);
        ss_n <= 0;
        pword <= 16'h1234;
        go <= 1;
        poll(5'h00, 0);
        go <= 0;
        ss_n <= 1;
        chk({fck_oe_n, aclk_oe_n}, 2'b11);
        rchk(5'h0c, 16'h1234);
        chk(prx, 16'h5aa5);
        bus(1, 5'h00, 16'h0000);
        $display("test slave done");
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        test_done();
    end
    initial
    begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 0;
        t_regs();
        t_master(1'b1, 16'h3c96, 16'ha55a);
        t_master(1'b0, 16'h8001, 16'h7ffe);
        t_ovf();
        t_slave();
        test_done();
    end
endmodule
bind seb_core seb_core_properties chk_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .irq_o(irq_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .first_port_clock_output_oe_n_o(first_port_clock_output_oe_n_o),
    .alternate_fixed_clock_pin_oe_n_o(alternate_fixed_clock_pin_oe_n_o)
);
`default_nettype wire
